/* File: rtl/hss_defines.svh */
// offsets, field positions, reset values and timing counts of the home search sequencer
`ifndef HSS_DEFINES_SVH
`define HSS_DEFINES_SVH
`define HSS_REG_CTRL      8'h00
`define HSS_REG_METHOD    8'h04
`define HSS_REG_SPEED1    8'h08
`define HSS_REG_SPEED2    8'h0C
`define HSS_REG_RAMP      8'h10
`define HSS_REG_OFFSET    8'h14
`define HSS_REG_HOLD      8'h18
`define HSS_REG_TIMEOUT   8'h1C
`define HSS_REG_STATUS    8'h20
`define HSS_REG_IRQ_STAT  8'h24
`define HSS_REG_IRQ_MASK  8'h28
`define HSS_SRC_OFF       2'h0
`define HSS_SRC_POWERON   2'h1
`define HSS_SRC_TRIGGER   2'h2
`define HSS_SRC_NOW       2'h3
`define HSS_DIG_DIR       0
`define HSS_DIG_REF       4
`define HSS_DIG_AFTER_REF 8
`define HSS_DIG_AFTER_Z   12
`define HSS_METHOD_RST    16'h0000
`define HSS_SPEED1_RST    15'h01F4
`define HSS_SPEED1_MAX    15'h4E20
`define HSS_SPEED2_RST    15'h00C8
`define HSS_SPEED2_MAX    15'h2710
`define HSS_RAMP_RST      10'h000
`define HSS_RAMP_MAX      10'h3E8
`define HSS_HOLD_RST      15'h0064
`define HSS_HOLD_MIN      15'h0001
`define HSS_HOLD_MAX      15'h7530
`define HSS_TMO_RST       16'h2710
`define HSS_TMO_MIN       16'h000A
`define HSS_RAMP_FULL     32'h00004E20
`define HSS_IRQ_DONE      0
`define HSS_IRQ_ERR       1
`define HSS_CLK_NS        4
`define HSS_MS_NS         1000000
`define HSS_CYC_PER_MS    ((`HSS_MS_NS + `HSS_CLK_NS - 1) / `HSS_CLK_NS)
`endif

/* File: rtl/hss_pkg.sv */
// types of the home search sequencer
`default_nettype none
package hss_pkg;
	typedef enum logic [2:0] {
		HSS_IDLE      = 3'b000,
		HSS_SEEK_REF  = 3'b001,
		HSS_SEEK_EDGE = 3'b010,
		HSS_STOPPING  = 3'b011,
		HSS_RETURN    = 3'b100,
		HSS_OFFSET    = 3'b101,
		HSS_DONE      = 3'b110,
		HSS_FAULT     = 3'b111
	} hss_state_t;
endpackage : hss_pkg
`default_nettype wire

/* File: rtl/hss_ramp.sv */
// linear speed ramp generator
`default_nettype none
`include "hss_defines.svh"
module hss_ramp #(
	parameter int CYC_PER_MS = `HSS_CYC_PER_MS
) (
	input  wire logic clk,    // system clock
	input  wire logic rst_n,  // async reset, low
	hss_ramp_if.ramp  rif     // target in, speed out
);
	logic [31:0] acc;
	logic [31:0] span;

	if (CYC_PER_MS < 1 || CYC_PER_MS > 4000000) begin : g_bad_cyc
		$error("hss_ramp cycles per ms out of range");
	end

	// full scale speed is reached in ramp_ms milliseconds
	assign span = 32'(rif.ramp_ms) * 32'(CYC_PER_MS);
	assign rif.at_target = (rif.current == rif.target);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc         <= '0;
			rif.current <= '0;
		end else if (rif.ramp_ms == '0) begin
			acc         <= '0;
			rif.current <= rif.target;
		end else if (rif.at_target) begin
			acc <= '0;
		end else if (acc + `HSS_RAMP_FULL >= span) begin
			acc <= acc + `HSS_RAMP_FULL - span;
			if (rif.target > rif.current) begin
				rif.current <= rif.current + 16'sh0001;
			end else begin
				rif.current <= rif.current - 16'sh0001;
			end
		end else begin
			acc <= acc + `HSS_RAMP_FULL;
		end
	end

	a_ramp_bypass: assert property (@(posedge clk) disable iff (!rst_n)
		(rif.ramp_ms == '0) |=> rif.current == $past(rif.target))
		else $error("zero ramp time did not jump to target");
	a_ramp_single: assert property (@(posedge clk) disable iff (!rst_n)
		($past(rif.ramp_ms) != '0) |-> (rif.current - $past(rif.current)) inside {16'sh0000, 16'sh0001, 16'shFFFF})
		else $error("ramp stepped by more than one unit");
endmodule : hss_ramp
`default_nettype wire

/* File: rtl/hss_ramp_if.sv */
// speed ramp request and answer between sequencer and ramp generator
`default_nettype none
interface hss_ramp_if;
	logic signed [15:0] target;
	logic signed [15:0] current;
	logic               at_target;
	logic        [9:0]  ramp_ms;
	modport seq  (output target, output ramp_ms, input current, input at_target);
	modport ramp (input target, input ramp_ms, output current, output at_target);
endinterface : hss_ramp_if
`default_nettype wire

/* File: rtl/hss_sync.sv */
// three flip-flop pin synchroniser with agreement filter
`default_nettype none
module hss_sync #(
	parameter int W = 6
) (
	input  wire logic         clk,    // system clock
	input  wire logic         rst_n,  // async reset, low
	input  wire logic [W-1:0] pin,    // raw pins
	output logic      [W-1:0] level   // filtered levels
);
	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;

	if (W < 1) begin : g_bad_w
		$error("hss_sync width must be positive");
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1 <= '0;
			ff2 <= '0;
			ff3 <= '0;
		end else begin
			ff1 <= pin;
			ff2 <= ff1;
			ff3 <= ff2;
		end
	end

	// a bit moves only once the second and third stage agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (ff2[i] == ff3[i]) begin
					level[i] <= ff3[i];
				end
			end
		end
	end

	a_sync_agree: assert property (@(posedge clk) disable iff (!rst_n)
		(level != $past(level)) |-> ($past(level ^ ff3) & ~$past(ff2 ^ ff3)) == (level ^ $past(level)))
		else $error("level changed without stage agreement");
endmodule : hss_sync
`default_nettype wire

/* File: rtl/hss_top.sv */
// home search sequencer with APB registers
//
// The APB interface to the registers and the placing of the registers were decided locally.
`default_nettype none
`include "hss_defines.svh"
module hss_top
	import hss_pkg::*;
#(
	parameter int CYC_PER_MS = `HSS_CYC_PER_MS
) (
	input  wire logic        pclk,                // 250 MHz clock
	input  wire logic        presetn,             // async reset, low
	input  wire logic [7:0]  paddr,               // APB address
	input  wire logic        psel,                // APB select
	input  wire logic        penable,             // APB enable
	input  wire logic        pwrite,              // APB direction
	input  wire logic [31:0] pwdata,              // APB write data
	output logic      [31:0] prdata,              // APB read data
	output logic             pready,              // APB ready
	output logic             pslverr,             // APB error
	input  wire logic        limit_fwd,           // forward travel limit pin
	input  wire logic        limit_rev,           // reverse travel limit pin
	input  wire logic        home_detector_input, // external detector pin
	input  wire logic        z_pulse,             // encoder Z pulse pin
	input  wire logic        start_trigger,       // start input pin
	input  wire logic        drive_enabled,       // drive enable state pin
	input  wire logic [31:0] encoder_pos,         // position, same clock
	output logic      [15:0] speed_cmd,           // signed speed, 0.1 rpm
	output logic             homing_busy,         // search running
	output logic             homing_done,         // completion signal
	output logic             homing_error,        // search aborted
	output logic      [31:0] home_position,       // located home
	output logic             irq                  // interrupt level
);
	hss_state_t state;
	hss_state_t after;
	logic [1:0]  start_src;
	logic [15:0] method;
	logic [14:0] speed1;
	logic [14:0] speed2;
	logic [9:0]  ramp_ms;
	logic [31:0] offset;
	logic [14:0] hold_ms;
	logic [15:0] tmo_ms;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_mask;
	logic [21:0] div_cnt;
	logic        ms_tick;
	logic [15:0] ms_cnt;
	logic        tmr_clr;
	logic [5:0]  pins;
	logic [5:0]  pins_d;
	logic        pwr_pend;
	logic        imm_req;
	logic        seek_fwd;
	logic        move_fwd;
	logic        start;
	logic        busy;
	logic        ref_hit;
	logic        edge_hit;
	logic        reached;
	logic        abort;
	logic        wr_fire;
	logic        ev_done;
	logic        ev_err;
	logic [31:0] rd_val;
	logic signed [31:0] pos;
	logic signed [31:0] home;

	hss_ramp_if rif ();

	if (CYC_PER_MS < 2 || CYC_PER_MS > 4000000) begin : g_bad_cyc
		$error("cycles per ms out of range");
	end

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a[1:0] == 2'h0) && (a <= `HSS_REG_IRQ_MASK);
	endfunction : reg_hit

	function automatic logic [3:0] digit(input logic [15:0] m, input int lsb);
		digit = m[lsb +: 4];
	endfunction : digit

	function automatic logic signed [31:0] goal_of(input hss_state_t st, input logic signed [31:0] h,
		input logic [31:0] off);
		goal_of = (st == HSS_RETURN) ? h : 32'(h + $signed(off));
	endfunction : goal_of

	function automatic logic [14:0] clamp15(input logic [31:0] v, input logic [14:0] lo, input logic [14:0] hi);
		if (v > 32'(hi)) begin
			clamp15 = hi;
		end else if (v < 32'(lo)) begin
			clamp15 = lo;
		end else begin
			clamp15 = v[14:0];
		end
	endfunction : clamp15

	hss_sync #(.W(6)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.pin   ({drive_enabled, start_trigger, z_pulse, home_detector_input, limit_rev, limit_fwd}),
		.level (pins)
	);

	hss_ramp #(.CYC_PER_MS(CYC_PER_MS)) u_ramp (
		.clk   (pclk),
		.rst_n (presetn),
		.rif   (rif)
	);

	assign pos     = $signed(encoder_pos);
	assign wr_fire = psel && penable && pready && pwrite && reg_hit(paddr);
	assign busy    = !(state inside {HSS_IDLE, HSS_DONE, HSS_FAULT});

	assign abort = busy && (!pins[5] || (ms_cnt >= tmo_ms));

	always_comb begin
		unique case (start_src)
			`HSS_SRC_POWERON: start = pwr_pend;
			`HSS_SRC_TRIGGER: start = pins[4] && !pins_d[4];
			`HSS_SRC_NOW:     start = imm_req;
			default:          start = 1'b0;
		endcase
		start = start && pins[5] && (state == HSS_IDLE);
	end

	// limits never reach the edge search; they stop and then go to the offset move
	always_comb begin
		unique case (digit(method, `HSS_DIG_REF))
			4'h0:    ref_hit = seek_fwd ? pins[0] : pins[1];
			4'h1:    ref_hit = pins[2];
			4'h2:    ref_hit = pins[3] && !pins_d[3];
			4'h3:    ref_hit = seek_fwd ? (pos >= 0) : (pos <= 0);
			default: ref_hit = 1'b0;
		endcase
	end

	assign edge_hit = (digit(method, `HSS_DIG_AFTER_REF) == 4'h3) ? (pins[2] && !pins_d[2])
		: (pins[3] && !pins_d[3]);
	assign reached  = move_fwd ? (pos >= goal_of(state, home, offset)) : (pos <= goal_of(state, home, offset));

	always_comb begin
		unique case (state)
			HSS_SEEK_REF:               rif.target = seek_fwd ? $signed({1'b0, speed1}) : -$signed({1'b0, speed1});
			HSS_SEEK_EDGE:              rif.target = seek_fwd ? $signed({1'b0, speed2}) : -$signed({1'b0, speed2});
			HSS_RETURN:                 rif.target = move_fwd ? $signed({1'b0, speed2}) : -$signed({1'b0, speed2});
			// zero offset: already at home, so no kick before the done state
			HSS_OFFSET:                 rif.target = (offset == '0) ? 16'sh0000
				: (move_fwd ? $signed({1'b0, speed2}) : -$signed({1'b0, speed2}));
			default:                    rif.target = 16'sh0000;
		endcase
	end
	assign rif.ramp_ms = ramp_ms;

	// restarting the divider too keeps every timed span at least its full length
	assign tmr_clr = start || (state == HSS_STOPPING && after == HSS_DONE && rif.at_target)
		|| (state == HSS_OFFSET && offset == '0);

	// millisecond enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			ms_tick <= 1'b0;
		end else if (tmr_clr) begin
			div_cnt <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (div_cnt == 22'(CYC_PER_MS - 1));
			div_cnt <= (div_cnt == 22'(CYC_PER_MS - 1)) ? '0 : div_cnt + 22'h000001;
		end
	end

	// search timer, doubles as completion hold timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt <= '0;
		end else if (tmr_clr) begin
			ms_cnt <= '0;
		end else if (ms_tick && ms_cnt != 16'hFFFF) begin
			ms_cnt <= ms_cnt + 16'h0001;
		end
	end

	// start request bookkeeping; power-on start fires only once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_pend <= 1'b1;
			imm_req  <= 1'b0;
			pins_d   <= '0;
		end else begin
			pins_d <= pins;
			// armed from reset until the first start or another source is chosen
			if (start || (wr_fire && paddr == `HSS_REG_CTRL && pwdata[1:0] != `HSS_SRC_POWERON)) begin
				pwr_pend <= 1'b0;
			end
			if (wr_fire && paddr == `HSS_REG_CTRL && pwdata[1:0] == `HSS_SRC_NOW) begin
				imm_req <= 1'b1;
			end else if (start || start_src != `HSS_SRC_NOW) begin
				imm_req <= 1'b0;
			end
		end
	end

	// sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= HSS_IDLE;
			after    <= HSS_IDLE;
			seek_fwd <= 1'b0;
			move_fwd <= 1'b0;
			home     <= '0;
		end else if (abort) begin
			state <= HSS_FAULT;
		end else begin
			unique case (state)
				HSS_IDLE: if (start) begin
					seek_fwd <= method[`HSS_DIG_DIR];
					state    <= HSS_SEEK_REF;
				end
				HSS_SEEK_REF: if (ref_hit) begin
					if (digit(method, `HSS_DIG_REF) == 4'h0 || digit(method, `HSS_DIG_AFTER_REF) == 4'h0) begin
						home  <= pos;
						after <= HSS_OFFSET;
						state <= HSS_STOPPING;
					end else begin
						seek_fwd <= (digit(method, `HSS_DIG_AFTER_REF) == 4'h2) ? seek_fwd : !seek_fwd;
						state    <= HSS_SEEK_EDGE;
					end
				end
				HSS_SEEK_EDGE: if (edge_hit) begin
					home  <= pos;
					after <= (digit(method, `HSS_DIG_AFTER_Z) == 4'h1) ? HSS_RETURN : HSS_OFFSET;
					state <= HSS_STOPPING;
				end
				HSS_STOPPING: if (rif.at_target) begin
					move_fwd <= goal_of(after, home, offset) > pos;
					state    <= after;
				end
				HSS_RETURN: if (reached) begin
					after <= HSS_OFFSET;
					state <= HSS_STOPPING;
				end
				HSS_OFFSET: if (offset == '0) begin
					state <= HSS_DONE;
				end else if (reached) begin
					after <= HSS_DONE;
					state <= HSS_STOPPING;
				end
				HSS_DONE: if (ms_cnt >= 16'(hold_ms)) begin
					state <= HSS_IDLE;
				end
				HSS_FAULT: if (rif.at_target) begin
					state <= HSS_IDLE;
				end
			endcase
		end
	end

	assign ev_done = (state == HSS_OFFSET && offset == '0) || (state == HSS_STOPPING && after == HSS_DONE
		&& rif.at_target && !abort);
	assign ev_err  = abort;

	// outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_cmd     <= '0;
			homing_busy   <= 1'b0;
			homing_done   <= 1'b0;
			homing_error  <= 1'b0;
			home_position <= '0;
			irq           <= 1'b0;
		end else begin
			speed_cmd     <= rif.current;
			homing_busy   <= busy;
			homing_done   <= (state == HSS_DONE);
			home_position <= 32'(home + $signed(offset));
			irq           <= |(irq_stat & irq_mask);
			if (ev_err) begin
				homing_error <= 1'b1;
			end else if (start) begin
				homing_error <= 1'b0;
			end
		end
	end

	// settings; out-of-range writes clamp to the nearest limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_src <= `HSS_SRC_OFF;
			method    <= `HSS_METHOD_RST;
			speed1    <= `HSS_SPEED1_RST;
			speed2    <= `HSS_SPEED2_RST;
			ramp_ms   <= `HSS_RAMP_RST;
			offset    <= '0;
			hold_ms   <= `HSS_HOLD_RST;
			tmo_ms    <= `HSS_TMO_RST;
			irq_mask  <= '0;
		end else if (wr_fire) begin
			unique case (paddr)
				`HSS_REG_CTRL:     start_src <= pwdata[1:0];
				`HSS_REG_METHOD:   method    <= pwdata[15:0];
				`HSS_REG_SPEED1:   speed1    <= clamp15(pwdata, 15'h0000, `HSS_SPEED1_MAX);
				`HSS_REG_SPEED2:   speed2    <= clamp15(pwdata, 15'h0000, `HSS_SPEED2_MAX);
				`HSS_REG_RAMP:     ramp_ms   <= (pwdata > 32'(`HSS_RAMP_MAX)) ? `HSS_RAMP_MAX : pwdata[9:0];
				`HSS_REG_OFFSET:   offset    <= (pwdata == 32'h80000000) ? 32'h80000001 : pwdata;
				`HSS_REG_HOLD:     hold_ms   <= clamp15(pwdata, `HSS_HOLD_MIN, `HSS_HOLD_MAX);
				`HSS_REG_TIMEOUT:  tmo_ms    <= (pwdata[15:0] < `HSS_TMO_MIN || pwdata[31:16] != '0)
					? ((pwdata[31:16] != '0) ? 16'hFFFF : `HSS_TMO_MIN) : pwdata[15:0];
				`HSS_REG_IRQ_MASK: irq_mask  <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// sticky events; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~((wr_fire && paddr == `HSS_REG_IRQ_STAT) ? pwdata[1:0] : 2'h0))
				| {ev_err, ev_done};
		end
	end

	always_comb begin
		unique case (paddr)
			`HSS_REG_CTRL:     rd_val = {30'h00000000, start_src};
			`HSS_REG_METHOD:   rd_val = {16'h0000, method};
			`HSS_REG_SPEED1:   rd_val = {17'h00000, speed1};
			`HSS_REG_SPEED2:   rd_val = {17'h00000, speed2};
			`HSS_REG_RAMP:     rd_val = {22'h000000, ramp_ms};
			`HSS_REG_OFFSET:   rd_val = offset;
			`HSS_REG_HOLD:     rd_val = {17'h00000, hold_ms};
			`HSS_REG_TIMEOUT:  rd_val = {16'h0000, tmo_ms};
			`HSS_REG_STATUS:   rd_val = {25'h0000000, homing_error, homing_done, busy, 1'b0, state};
			`HSS_REG_IRQ_STAT: rd_val = {30'h00000000, irq_stat};
			`HSS_REG_IRQ_MASK: rd_val = {30'h00000000, irq_mask};
			default:           rd_val = 32'h00000000;
		endcase
	end

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !reg_hit(paddr);
			if (psel && penable && !pready && !pwrite) begin
				prdata <= reg_hit(paddr) ? rd_val : 32'h00000000;
			end
		end
	end

	a_src_now: assert property (@(posedge pclk) disable iff (!presetn)
		(state == HSS_IDLE && start_src == `HSS_SRC_NOW && imm_req && pins[5]) |=> state == HSS_SEEK_REF)
		else $error("immediate start not taken");
	a_first_dir: assert property (@(posedge pclk) disable iff (!presetn)
		(state == HSS_IDLE && start) |=> seek_fwd == $past(method[0]))
		else $error("first search direction wrong");
	a_z_reference: assert property (@(posedge pclk) disable iff (!presetn)
		(state == HSS_SEEK_REF && method[7:4] == 4'h2 && pins[3] && !pins_d[3] && !abort) |=> state != HSS_SEEK_REF)
		else $error("Z reference missed");
	a_opposite_dir: assert property (@(posedge pclk) disable iff (!presetn)
		(state == HSS_SEEK_REF && ref_hit && !abort && method[7:4] != 4'h0 && method[11:8] == 4'h1)
		|=> (state == HSS_SEEK_EDGE) && (seek_fwd != $past(seek_fwd)))
		else $error("second search not reversed");
	a_det_edge: assert property (@(posedge pclk) disable iff (!presetn)
		(state == HSS_SEEK_EDGE && method[11:8] == 4'h3 && pins[2] && !pins_d[2] && !abort)
		|=> state == HSS_STOPPING && home == $past(pos))
		else $error("detector edge not taken as origin");
	a_turn_back: assert property (@(posedge pclk) disable iff (!presetn)
		(state == HSS_SEEK_EDGE && edge_hit && !abort && method[15:12] == 4'h1) |=> after == HSS_RETURN)
		else $error("turn back not scheduled");
	a_speed_bounds: assert property (@(posedge pclk) disable iff (!presetn)
		speed1 <= `HSS_SPEED1_MAX && speed2 <= `HSS_SPEED2_MAX)
		else $error("search speed beyond range");
	a_zero_offset: assert property (@(posedge pclk) disable iff (!presetn)
		(state == HSS_OFFSET && offset == '0 && !abort) |=> state == HSS_DONE ##1 home_position == $past(home, 2))
		else $error("zero offset did not complete at home");
	a_done_level: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state == HSS_DONE) |=> homing_done [*2])
		else $error("completion signal not held");
	a_stop_held: assert property (@(posedge pclk) disable iff (!presetn)
		(state == HSS_DONE) |-> rif.target == 16'sh0000 && rif.current == 16'sh0000)
		else $error("motor not stopped at home");
	a_timeout: assert property (@(posedge pclk) disable iff (!presetn)
		(busy && ms_cnt >= tmo_ms) |=> state == HSS_FAULT ##1 homing_error)
		else $error("timeout did not abort");
endmodule : hss_top
`default_nettype wire

/* File: sim/home_search_sequencer_tb.sv */
// self-checking bench of the home search sequencer
`default_nettype none
module home_search_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start_trigger = 0;
	logic        drive_enabled = 1, lim_fwd = 0, lim_rev = 0;
	logic [15:0] meth [4] = '{16'h0020, 16'h0021, 16'h1121, 16'h0220};
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, encoder_pos, home_position, off, diff;
	logic [15:0] speed_cmd;
	logic        pready, pslverr, z_pulse, det, homing_busy, homing_done, homing_error, irq;
	logic [32:0] expq[$];
	int          fails = 0, n_checks = 0, cyc = 0, hold_cyc = 0;
	always #2 pclk = ~pclk;
	hss_top #(.CYC_PER_MS(10)) hss_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .limit_fwd(lim_fwd), .limit_rev(lim_rev), .home_detector_input(det),
		.z_pulse(z_pulse), .start_trigger(start_trigger), .drive_enabled(drive_enabled),
		.encoder_pos(encoder_pos), .speed_cmd(speed_cmd), .homing_busy(homing_busy),
		.homing_done(homing_done), .homing_error(homing_error), .home_position(home_position), .irq(irq));
	hss_motor_model hss_motor_model_i (.pclk(pclk), .presetn(presetn), .speed_cmd(speed_cmd),
		.encoder_pos(encoder_pos), .z_pulse(z_pulse), .det(det));
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	function automatic logic sig(input int k);
		case (k)
			0: return homing_busy;
			1: return homing_done;
			2: return homing_error;
			default: return speed_cmd != 16'h0;
		endcase
	endfunction : sig
	task automatic wt(input string nm, input int k, input logic v, input int lim);
		for (int i = 0; i < lim && sig(k) !== v; i++)
			@(posedge pclk);
		chk(nm, {32'h0, v}, {32'h0, sig(k)});
	endtask : wt
	// read answers are compared against the oldest note
	always @(posedge pclk) begin
		cyc++;
		// hold is 1 ms, ten cycles here, plus up to one tick of slack
		if (homing_done === 1'b1)
			hold_cyc++;
		else if (hold_cyc != 0) begin
			chk("hold", 33'h1, {32'h0, hold_cyc >= 10 && hold_cyc <= 20});
			hold_cyc = 0;
		end
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end else if (psel && penable && pready === 1'b1 && !pwrite)
			chk("read", expq.pop_front(), {pslverr, prdata});
	end
	initial begin
		void'($urandom(32'h5ED0471E));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h08, 33'h0_0000_01F4);
		rd(8'h0C, 33'h0_0000_00C8);
		rd(8'h18, 33'h0_0000_0064);
		rd(8'h1C, 33'h0_0000_2710);
		apb(1'b1, 8'h08, 32'h0000_5000);
		apb(1'b1, 8'h0C, 32'h0000_2800);
		apb(1'b1, 8'h18, 32'h0);
		rd(8'h08, 33'h0_0000_4E20);
		rd(8'h0C, 33'h0_0000_2710);
		rd(8'h18, 33'h0_0000_0001);
		rd(8'h2C, 33'h1_0000_0000);
		$display("test registers done");
		apb(1'b1, 8'h28, 32'h3);
		for (int d = 0; d < 4; d++) begin
			off = (d == 0) ? 32'h0 : 32'($urandom_range(255)) - 32'h80;
			apb(1'b1, 8'h14, off);
			apb(1'b1, 8'h04, {16'h0, meth[d]});
			apb(1'b1, 8'h00, (d == 0) ? 32'h1 : 32'h3);
			wt("moving", 3, 1'b1, 100);
			chk("direction", {32'h0, meth[d][0]}, {32'h0, ~speed_cmd[15]});
			wt("done", 1, 1'b1, 3000);
			diff = home_position - off;
			chk("home", 33'h1, {32'h0, diff[5:0] >= 6'd16 && diff[5:0] <= 6'd30});
			chk("stopped", 33'h0, {17'h0, speed_cmd});
			chk("irq", 33'h1, {32'h0, irq});
			rd(8'h24, 33'h1);
			apb(1'b1, 8'h24, 32'h1);
			rd(8'h24, 33'h0);
			wt("done end", 1, 1'b0, 40);
			$display("test homing method %0d done", d);
		end
		apb(1'b1, 8'h08, 32'h8);
		apb(1'b1, 8'h10, 32'h1);
		apb(1'b1, 8'h04, 32'h0000);
		apb(1'b1, 8'h00, 32'h3);
		wt("limit moving", 3, 1'b1, 100);
		repeat (20) @(posedge pclk);
		chk("ramp speed", 33'h0_0000_FFF8, {17'h0, speed_cmd});
		lim_rev <= 1'b1;
		wt("limit done", 1, 1'b1, 3000);
		chk("limit stop", 33'h0, {17'h0, speed_cmd});
		lim_rev <= 1'b0;
		wt("limit done end", 1, 1'b0, 100);
		$display("test limit reference done");
		apb(1'b1, 8'h1C, 32'h0);
		rd(8'h1C, 33'h0_0000_000A);
		apb(1'b1, 8'h04, 32'h0011);
		for (int s = 0; s < 3; s += 2) begin
			apb(1'b1, 8'h00, 32'(s));
			start_trigger <= 1'b1;
			repeat (8) @(posedge pclk);
			start_trigger <= 1'b0;
			repeat (8) @(posedge pclk);
			chk("trigger start", {32'h0, s == 2}, {32'h0, homing_busy});
		end
		// drive stays enabled through the search
		wt("timeout", 2, 1'b1, 400);
		wt("abort stop", 3, 1'b0, 20);
		// done bit of the limit test is still sticky
		rd(8'h24, 33'h3);
		$display("test timeout done");
		end_sim();
	end
endmodule : home_search_sequencer_tb
`default_nettype wire

/* File: sim/hss_motor_model.sv */
// motor, encoder and detector stand-in driven by the speed command
`default_nettype none
module hss_motor_model (
	input  wire logic        pclk,        // clock
	input  wire logic        presetn,     // async reset, low
	input  wire logic [15:0] speed_cmd,   // signed speed
	output logic      [31:0] encoder_pos, // position count
	output logic             z_pulse,     // eight counts of every 64
	output logic             det          // detector level
);
	timeunit 1ns;
	timeprecision 1ps;
	// one count a cycle keeps pin sync lag inside the pulse width
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			encoder_pos <= 32'h0;
		else if ($signed(speed_cmd) > 0)
			encoder_pos <= encoder_pos + 32'h1;
		else if ($signed(speed_cmd) < 0)
			encoder_pos <= encoder_pos - 32'h1;
	end
	assign z_pulse = (encoder_pos[5:3] == 3'h2);
	// far away on purpose: a detector search can only time out
	assign det = ($signed(encoder_pos) > 32'sh1000);
endmodule : hss_motor_model
`default_nettype wire
